//--- hdl/field_eval_pkg.sv
// shared constants, register map and carrier types for the field evaluation block
`default_nettype none
package field_eval_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_CASES = 10;
    localparam int NUM_FIELDS = 10;
    localparam int NUM_OUTS = 3;
    localparam int NUM_INS = 2;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam logic [13:0] MAX_DELAY_MS = 14'h2710;

    // ------------------------------------------------------------------
    // register map (word addresses on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] CASE_CFG_BASE = 8'h00;
    localparam logic [7:0] CASE_TIME_BASE = 8'h10;
    localparam logic [7:0] OUT_CFG_BASE = 8'h20;
    localparam logic [7:0] STATUS_ADDR = 8'h30;
    localparam logic [7:0] SCAN_CNT_ADDR = 8'h31;
    localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {STRAT_PIXEL, STRAT_BLANK, STRAT_CONTOUR, STRAT_IO_LINK} strat_t;
    typedef enum logic [1:0] {REL_NOW, REL_DELAY, REL_INPUT, REL_SPARE} rel_mode_t;

    typedef struct packed {
        logic [9:0] pad;
        logic [7:0] blank_size;
        logic [3:0] field;
        strat_t strat;
        logic [1:0] out_sel;
        logic in_en;
        logic in1_high;
        logic in2_high;
        logic negate;
        logic obs_en;
        logic enable;
    } case_cfg_t;

    typedef struct packed {
        logic [15:0] pad;
        logic [7:0] obs_resp;
        logic [7:0] resp;
    } case_time_t;

    typedef struct packed {
        logic [11:0] pad;
        logic [13:0] delay_ms;
        logic rst_in_level;
        logic rst_in_sel;
        rel_mode_t rel_mode;
        logic active_low;
        logic op_and;
    } out_cfg_t;

    // one per-field summary of a scan, delivered by the measurement front end
    typedef struct packed {
        logic second_echo;
        logic [3:0] field;
        logic [7:0] obj_run;
        logic [8:0] obj_loc;
        logic [7:0] gap_run;
        logic [8:0] gap_loc;
        logic [7:0] near_run;
        logic dazzle;
    } meas_t;

    localparam case_cfg_t CASE_CFG_RST = '0;
    localparam case_time_t CASE_TIME_RST = '0;
    localparam out_cfg_t OUT_CFG_RST = '0;
    localparam meas_t MEAS_RST = '0;

endpackage
`default_nettype wire

//--- hdl/out_release.sv
// hold and release sequencing for one switching output
`timescale 1ns/100ps
`default_nettype none
module out_release
    import field_eval_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ms_tick,
    input wire logic raw,
    input wire rel_mode_t rel_mode,
    input wire logic [13:0] delay_ms,
    input wire logic in_match,
    output logic state
);

    typedef enum logic [1:0] {S_IDLE, S_ON, S_HOLD} rel_state_t;

    rel_state_t state_q;
    logic [13:0] cnt_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= S_IDLE;
            cnt_q <= '0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (raw) begin
                        state_q <= S_ON;
                    end
                end
                S_ON: begin
                    if (!raw) begin
                        // limitation: delay beyond the maximum is clipped, not wrapped
                        cnt_q <= (delay_ms > MAX_DELAY_MS) ? MAX_DELAY_MS : delay_ms;
                        if (rel_mode == REL_DELAY && delay_ms != '0) begin
                            state_q <= S_HOLD;
                        end else if (rel_mode == REL_INPUT) begin
                            state_q <= S_HOLD;
                        end else begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_HOLD: begin
                    if (raw) begin
                        state_q <= S_ON;
                    end else if (rel_mode == REL_INPUT) begin
                        if (in_match) begin
                            state_q <= S_IDLE;
                        end
                    end else if (ms_tick) begin
                        if (cnt_q <= 14'h0001) begin
                            state_q <= S_IDLE;
                        end
                        cnt_q <= cnt_q - 14'h0001;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    assign state = (state_q != S_IDLE);

endmodule
`default_nettype wire

//--- hdl/field_eval.sv
// field evaluation cases, output operators and register port
`timescale 1ns/100ps
`default_nettype none

module field_eval
    import field_eval_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    input wire logic meas_valid,
    input wire meas_t meas,
    input wire logic scan_done,
    input wire logic [NUM_INS-1:0] sw_in,
    output logic [NUM_OUTS-1:0] sw_out
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == {CNT_W{1'b1}}) ? v : v + 8'h01;
    endfunction

    function automatic logic pattern_match(input case_cfg_t cfg, input logic [1:0] ins);
        pattern_match = (ins[0] == cfg.in1_high) && (ins[1] == cfg.in2_high);
    endfunction

    function automatic logic [CNT_W-1:0] at_least_one(input logic [CNT_W-1:0] v);
        at_least_one = (v == '0) ? 8'h01 : v;
    endfunction

    // ------------------------------------------------------------------
    // input synchronisers and millisecond tick
    // ------------------------------------------------------------------
    logic [NUM_INS-1:0] in_meta_q;
    logic [NUM_INS-1:0] in_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_meta_q <= '0;
            in_q <= '0;
        end else begin
            in_meta_q <= sw_in;
            in_q <= in_meta_q;
        end
    end

    logic [31:0] ms_cnt_q;
    logic ms_tick;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ms_cnt_q <= '0;
        end else if (ms_cnt_q >= 32'(MS_CYCLES_P - 1)) begin
            ms_cnt_q <= '0;
        end else begin
            ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
        end
    end

    assign ms_tick = (ms_cnt_q >= 32'(MS_CYCLES_P - 1));

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    case_cfg_t case_cfg_q [NUM_CASES];
    case_time_t case_time_q [NUM_CASES];
    out_cfg_t out_cfg_q [NUM_OUTS];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int c = 0; c < NUM_CASES; c++) begin
                case_cfg_q[c] <= CASE_CFG_RST;
                case_time_q[c] <= CASE_TIME_RST;
            end
            for (int o = 0; o < NUM_OUTS; o++) begin
                out_cfg_q[o] <= OUT_CFG_RST;
            end
        end else if (reg_we) begin
            for (int c = 0; c < NUM_CASES; c++) begin
                if (reg_addr == CASE_CFG_BASE + 8'(c)) begin
                    case_cfg_q[c] <= case_cfg_t'({10'h000, reg_wdata[21:0]});
                end
                if (reg_addr == CASE_TIME_BASE + 8'(c)) begin
                    case_time_q[c] <= case_time_t'({16'h0000, reg_wdata[15:0]});
                end
            end
            for (int o = 0; o < NUM_OUTS; o++) begin
                if (reg_addr == OUT_CFG_BASE + 8'(o)) begin
                    out_cfg_q[o] <= out_cfg_t'({12'h000, reg_wdata[19:0]});
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // per-field measurement table, filled during the scan
    // ------------------------------------------------------------------
    meas_t meas_q [NUM_FIELDS];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int f = 0; f < NUM_FIELDS; f++) begin
                meas_q[f] <= MEAS_RST;
            end
        end else begin
            for (int f = 0; f < NUM_FIELDS; f++) begin
                // table is consumed at scan end; a write in that cycle belongs to the next scan
                if (meas_valid && !meas.second_echo && meas.field == 4'(f)) begin
                    meas_q[f] <= meas;
                end else if (scan_done) begin
                    meas_q[f] <= MEAS_RST;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // case evaluation, all cases side by side
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] persist_q [NUM_CASES];
    logic [8:0] loc_q [NUM_CASES];
    logic [CNT_W-1:0] near_q [NUM_CASES];
    logic [CNT_W-1:0] dazzle_q [NUM_CASES];
    logic [NUM_CASES-1:0] result_q;
    logic [NUM_CASES-1:0] active_q;

    logic [CNT_W-1:0] persist_d [NUM_CASES];
    logic [8:0] loc_d [NUM_CASES];
    logic [CNT_W-1:0] near_d [NUM_CASES];
    logic [CNT_W-1:0] dazzle_d [NUM_CASES];
    logic [NUM_CASES-1:0] result_d;
    logic [NUM_CASES-1:0] active_d;

    always_comb begin
        meas_t m;
        logic raw;
        logic [8:0] loc;
        logic det;
        logic obs;
        m = MEAS_RST;
        raw = 1'b0;
        loc = '0;
        det = 1'b0;
        obs = 1'b0;
        for (int c = 0; c < NUM_CASES; c++) begin
            m = (case_cfg_q[c].field < 4'(NUM_FIELDS)) ? meas_q[case_cfg_q[c].field] : MEAS_RST;
            active_d[c] = case_cfg_q[c].enable &&
                          (!case_cfg_q[c].in_en || pattern_match(case_cfg_q[c], in_q));
            case (case_cfg_q[c].strat)
                STRAT_PIXEL: begin
                    raw = (m.obj_run != '0);
                    loc = m.obj_loc;
                end
                STRAT_BLANK: begin
                    raw = (m.obj_run > case_cfg_q[c].blank_size);
                    loc = m.obj_loc;
                end
                STRAT_CONTOUR: begin
                    raw = (m.gap_run > case_cfg_q[c].blank_size);
                    loc = m.gap_loc;
                end
                default: begin
                    raw = 1'b0;
                    loc = '0;
                end
            endcase
            if (raw && persist_q[c] != '0 && loc == loc_q[c]) begin
                persist_d[c] = sat_inc(persist_q[c]);
            end else begin
                persist_d[c] = raw ? 8'h01 : 8'h00;
            end
            loc_d[c] = loc;
            det = raw && (persist_d[c] >= at_least_one(case_time_q[c].resp));
            near_d[c] = (m.near_run != '0 && m.near_run <= case_cfg_q[c].blank_size) ?
                        sat_inc(near_q[c]) : 8'h00;
            dazzle_d[c] = m.dazzle ? sat_inc(dazzle_q[c]) : 8'h00;
            obs = case_cfg_q[c].obs_en &&
                  ((near_d[c] >= at_least_one(case_time_q[c].obs_resp)) ||
                   (dazzle_d[c] > case_time_q[c].obs_resp));
            if (case_cfg_q[c].strat == STRAT_IO_LINK) begin
                // linkage follows input 1; the input pattern still gates activation
                result_d[c] = in_q[0] ^ case_cfg_q[c].negate;
            end else begin
                result_d[c] = (det || obs) ^ case_cfg_q[c].negate;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int c = 0; c < NUM_CASES; c++) begin
                persist_q[c] <= '0;
                loc_q[c] <= '0;
                near_q[c] <= '0;
                dazzle_q[c] <= '0;
            end
            result_q <= '0;
            active_q <= '0;
        end else if (scan_done) begin
            for (int c = 0; c < NUM_CASES; c++) begin
                persist_q[c] <= persist_d[c];
                loc_q[c] <= loc_d[c];
                near_q[c] <= near_d[c];
                dazzle_q[c] <= dazzle_d[c];
            end
            result_q <= result_d;
            active_q <= active_d;
        end
    end

    // ------------------------------------------------------------------
    // output operators
    // ------------------------------------------------------------------
    logic [NUM_OUTS-1:0] out_raw_d;
    logic [NUM_OUTS-1:0] out_raw_q;

    always_comb begin
        logic any_set;
        logic all_set;
        logic used;
        any_set = 1'b0;
        all_set = 1'b1;
        used = 1'b0;
        for (int o = 0; o < NUM_OUTS; o++) begin
            any_set = 1'b0;
            all_set = 1'b1;
            used = 1'b0;
            for (int c = 0; c < NUM_CASES; c++) begin
                // an inactive case is left out rather than counted as clear
                if (active_d[c] && case_cfg_q[c].out_sel == 2'(o)) begin
                    used = 1'b1;
                    any_set = any_set | result_d[c];
                    all_set = all_set & result_d[c];
                end
            end
            out_raw_d[o] = used && (out_cfg_q[o].op_and ? all_set : any_set);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_raw_q <= '0;
        end else if (scan_done) begin
            out_raw_q <= out_raw_d;
        end
    end

    // ------------------------------------------------------------------
    // release sequencing and polarity
    // ------------------------------------------------------------------
    logic [NUM_OUTS-1:0] out_state;

    for (genvar o = 0; o < NUM_OUTS; o++) begin : g_out
        out_release u_rel (
            .clk(clk),
            .sys_rst(sys_rst),
            .ms_tick(ms_tick),
            .raw(out_raw_q[o]),
            .rel_mode(out_cfg_q[o].rel_mode),
            .delay_ms(out_cfg_q[o].delay_ms),
            .in_match(in_q[out_cfg_q[o].rst_in_sel] == out_cfg_q[o].rst_in_level),
            .state(out_state[o])
        );
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sw_out <= '0;
        end else begin
            for (int o = 0; o < NUM_OUTS; o++) begin
                sw_out[o] <= out_state[o] ^ out_cfg_q[o].active_low;
            end
        end
    end

    // ------------------------------------------------------------------
    // scan counter and register read port
    // ------------------------------------------------------------------
    logic [15:0] scan_cnt_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scan_cnt_q <= '0;
        end else if (scan_done) begin
            scan_cnt_q <= scan_cnt_q + 16'h0001;
        end
    end

    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = UNMAPPED_VALUE;
        for (int c = 0; c < NUM_CASES; c++) begin
            if (reg_addr == CASE_CFG_BASE + 8'(c)) begin
                rdata_d = 32'(case_cfg_q[c]);
            end
            if (reg_addr == CASE_TIME_BASE + 8'(c)) begin
                rdata_d = 32'(case_time_q[c]);
            end
        end
        for (int o = 0; o < NUM_OUTS; o++) begin
            if (reg_addr == OUT_CFG_BASE + 8'(o)) begin
                rdata_d = 32'(out_cfg_q[o]);
            end
        end
        if (reg_addr == STATUS_ADDR) begin
            rdata_d = {7'h00, in_q, out_state, active_q, result_q};
        end
        if (reg_addr == SCAN_CNT_ADDR) begin
            rdata_d = {16'h0000, scan_cnt_q};
        end
    end

    // data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_re) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule
`default_nettype wire

//--- verif/field_eval_monitor.sv
// port checks for the field evaluation block
`timescale 1ns/100ps
`default_nettype none
module field_eval_monitor
    import field_eval_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    input wire logic [31:0] reg_rdata,
    input wire logic meas_valid,
    input wire meas_t meas,
    input wire logic scan_done,
    input wire logic [NUM_INS-1:0] sw_in,
    input wire logic [NUM_OUTS-1:0] sw_out
);
    // ----
    // helpers
    // ----
    logic cfg_seen_q;
    logic [15:0] scans_q;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // until the first register write no output may switch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_seen_q <= 1'b0;
        end else if (reg_we) begin
            cfg_seen_q <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scans_q <= 16'h0000;
        end else if (scan_done) begin
            scans_q <= scans_q + 16'h0001;
        end
    end
    // ----
    // checks
    // ----
    sequence s_same_rd;
        reg_re && reg_addr == $past(reg_addr);
    endsequence
    sequence s_quiet_in;
        $stable(sw_in) [*3];
    endsequence
    a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> sw_out == '0 && reg_rdata == '0)
        else $error("reset left an output set");
    a_unconfig_quiet: assert property (!cfg_seen_q |-> sw_out == '0)
        else $error("output switched with no case enabled");
    a_unmapped_zero: assert property (reg_re && reg_addr inside {[8'h0A:8'h0F], [8'h1A:8'h1F],
        [8'h23:8'h2F], [8'h32:8'hFF]} |=> reg_rdata == UNMAPPED_VALUE)
        else $error("unmapped read not zero");
    a_case_readback: assert property ((reg_we && reg_addr < 8'h0A) ##1 s_same_rd
        |=> reg_rdata == ($past(reg_wdata, 2) & 32'h003F_FFFF))
        else $error("case setup read back wrong");
    a_time_readback: assert property ((reg_we && reg_addr inside {[8'h10:8'h19]}) ##1 s_same_rd
        |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000_FFFF))
        else $error("case timing read back wrong");
    a_scan_count: assert property (reg_re && reg_addr == SCAN_CNT_ADDR && !scan_done
        |=> reg_rdata[15:0] == $past(scans_q))
        else $error("scan count wrong");
    a_input_sync: assert property (s_quiet_in ##0 (reg_re && reg_addr == STATUS_ADDR)
        |=> reg_rdata[24:23] == $past(sw_in))
        else $error("input state in status wrong");
endmodule
bind field_eval field_eval_monitor #(
    .MS_CYCLES_P(MS_CYCLES_P)
) mon (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_rdata(reg_rdata),
    .meas_valid(meas_valid),
    .meas(meas),
    .scan_done(scan_done),
    .sw_in(sw_in),
    .sw_out(sw_out)
);
`default_nettype wire

//--- verif/ext_io.sv
// model of the external equipment wired to the switching inputs
`timescale 1ns/100ps
`default_nettype none
module ext_io
    import field_eval_pkg::*;
(
    input wire logic clk,
    output logic [NUM_INS-1:0] sw_in
);
    initial sw_in = '0;
    // contacts are held three clocks so the two-stage synchroniser has passed them on
    task automatic drive(input logic [NUM_INS-1:0] v);
        sw_in <= v;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the field evaluation block
`timescale 1ns/100ps
`default_nettype none
module testbench
    import field_eval_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [31:0] reg_rdata;
    logic meas_valid;
    meas_t meas;
    logic scan_done;
    logic [NUM_INS-1:0] sw_in;
    logic [NUM_OUTS-1:0] sw_out;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    ext_io io (.clk(clk), .sw_in(sw_in));
    field_eval #(.MS_CYCLES_P(10)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .meas_valid(meas_valid), .meas(meas), .scan_done(scan_done), .sw_in(sw_in), .sw_out(sw_out));
    // ----
    // tasks
    // ----
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_out(input logic [2:0] exp);
        n_compared++;
        if (sw_out !== exp) begin
            bad_count++;
            $display("[ERR] %0t outputs %b expected %b", $time, sw_out, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_re <= 1'b0;
        @(posedge clk);
        chk_rd(reg_rdata, exp);
    endtask
    // every write is read back at once; bits beyond the fields read as zero
    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_we <= 1'b0;
        rd(a, d & (a < 8'h10 ? 32'h003F_FFFF : a < 8'h20 ? 32'h0000_FFFF : 32'h000F_FFFF));
    endtask
    function automatic logic [31:0] cc(input strat_t s, input logic [3:0] f, input logic [1:0] o,
        input logic [7:0] b, input logic [5:0] fl);
        return {10'h000, b, f, s, o, fl};
    endfunction
    task automatic mv(input logic e, input logic [3:0] f, input logic [7:0] o, input logic [8:0] l,
        input logic [7:0] g, input logic [7:0] n, input logic z);
        meas_valid <= 1'b1;
        meas <= {e, f, o, l, g, l, n, z};
        @(posedge clk);
    endtask
    task automatic ob(input logic [3:0] f, input logic [7:0] o, input logic [8:0] l);
        mv(1'b0, f, o, l, 8'h00, 8'h00, 1'b0);
    endtask
    task automatic sd(input logic [2:0] exp);
        meas_valid <= 1'b0;
        scan_done <= 1'b1;
        @(posedge clk);
        scan_done <= 1'b0;
        repeat (4) @(posedge clk);
        chk_out(exp);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    // ----
    // tests
    // ----
    initial begin
        reg_addr <= 8'h00;
        reg_wdata <= 32'h0000_0000;
        reg_we <= 1'b0;
        reg_re <= 1'b0;
        meas_valid <= 1'b0;
        meas <= MEAS_RST;
        scan_done <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(STATUS_ADDR, 32'h0);
        rd(8'h0A, UNMAPPED_VALUE);
        rd(8'h40, UNMAPPED_VALUE);
        wrc(CASE_TIME_BASE, 32'h0000_0001);
        wrc(CASE_CFG_BASE, cc(STRAT_PIXEL, 4'h0, 2'd0, 8'h00, 6'h01));
        ob(4'h0, 8'h05, 9'h010);
        sd(3'b001);
        sd(3'b000);
        mv(1'b1, 4'h0, 8'h05, 9'h010, 8'h00, 8'h00, 1'b0);
        sd(3'b000);
        ob(4'h3, 8'h05, 9'h010);
        sd(3'b000);
        rd(SCAN_CNT_ADDR, 32'h0000_0004);
        done("pixel");
        wrc(CASE_TIME_BASE, 32'h0000_0002);
        ob(4'h0, 8'h05, 9'h010);
        sd(3'b000);
        ob(4'h0, 8'h05, 9'h020);
        sd(3'b000);
        ob(4'h0, 8'h05, 9'h020);
        sd(3'b001);
        wrc(CASE_TIME_BASE, 32'h0000_0001);
        wrc(CASE_CFG_BASE, cc(STRAT_BLANK, 4'h0, 2'd0, 8'h04, 6'h01));
        ob(4'h0, 8'h04, 9'h010);
        sd(3'b000);
        ob(4'h0, 8'h05, 9'h010);
        sd(3'b001);
        wrc(CASE_CFG_BASE, cc(STRAT_CONTOUR, 4'h0, 2'd0, 8'h04, 6'h01));
        mv(1'b0, 4'h0, 8'h00, 9'h010, 8'h04, 8'h00, 1'b0);
        sd(3'b000);
        mv(1'b0, 4'h0, 8'h00, 9'h010, 8'h05, 8'h00, 1'b0);
        sd(3'b001);
        done("strategies");
        wrc(CASE_CFG_BASE, cc(STRAT_PIXEL, 4'h0, 2'd0, 8'h00, 6'h05));
        sd(3'b001);
        wrc(OUT_CFG_BASE, 32'h0000_0002);
        chk_out(3'b000);
        ob(4'h0, 8'h05, 9'h010);
        sd(3'b001);
        wrc(OUT_CFG_BASE, 32'h0);
        wrc(CASE_CFG_BASE, 32'h0);
        done("polarity");
        wrc(CASE_CFG_BASE + 8'h1, cc(STRAT_IO_LINK, 4'h0, 2'd1, 8'h00, 6'h01));
        wrc(CASE_CFG_BASE + 8'h2, cc(STRAT_PIXEL, 4'h1, 2'd2, 8'h00, 6'h31));
        wrc(CASE_CFG_BASE + 8'h3, cc(STRAT_PIXEL, 4'h2, 2'd2, 8'h00, 6'h31));
        wrc(OUT_CFG_BASE + 8'h2, 32'h0000_0001);
        io.drive(2'b01);
        ob(4'h1, 8'h05, 9'h010);
        sd(3'b010);
        ob(4'h1, 8'h05, 9'h010);
        ob(4'h2, 8'h05, 9'h010);
        sd(3'b110);
        rd(STATUS_ADDR, 32'h00E0_380E);
        io.drive(2'b11);
        ob(4'h1, 8'h05, 9'h010);
        ob(4'h2, 8'h05, 9'h010);
        sd(3'b010);
        done("inputs");
        wrc(OUT_CFG_BASE + 8'h1, 32'h0000_0038);
        io.drive(2'b00);
        sd(3'b010);
        io.drive(2'b10);
        repeat (3) @(posedge clk);
        chk_out(3'b000);
        wrc(OUT_CFG_BASE + 8'h1, 32'h0000_0084);
        io.drive(2'b01);
        sd(3'b010);
        io.drive(2'b00);
        sd(3'b010);
        repeat (25) @(posedge clk);
        chk_out(3'b000);
        done("release");
        wrc(CASE_TIME_BASE + 8'h4, 32'h0000_0201);
        wrc(CASE_CFG_BASE + 8'h4, cc(STRAT_PIXEL, 4'h3, 2'd0, 8'h04, 6'h03));
        for (int i = 0; i < 2; i++) begin
            mv(1'b0, 4'h3, 8'h00, 9'h010, 8'h00, 8'h03, 1'b0);
            sd(i == 1 ? 3'b001 : 3'b000);
        end
        sd(3'b000);
        for (int i = 0; i < 3; i++) begin
            mv(1'b0, 4'h3, 8'h00, 9'h010, 8'h00, 8'h00, 1'b1);
            sd(i == 2 ? 3'b001 : 3'b000);
        end
        done("obstruction");
        end_of_test();
    end
endmodule
`default_nettype wire
